// >>> rtl/calcmd_ctrl.sv
// Calibration and coefficient command controller with AXI4-Lite registers
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R1: Byte and 16-bit word writes accepted, applied per byte strobe.
// R2: Supervisory/nonprivileged and standard/extended accesses honoured per mode enables.
// R3: A single byte write to the command register triggers a command.
// R4: Start-calibration halts sample processing, enters calibration, blinks the LED.
// R5: Every read during calibration returns 0x3C00.
// R6: Every write during calibration is discarded.
// R7: Converter self-cal, then 2.5/5/10 V references, then output channels.
// R8: Busy during calibration: no samples out, commands ignored.
// R9: Each data point is the average of many converter readings.
// R10: Unipolar channels fit two ranges, bipolar channels the three symmetric ones.
// R11: Polarity taken from bit 12 of each channel config register.
// R12: Host writes all channel config registers before starting calibration.
// R13: Calibration results stay in working memory only.
// R14: Upload copies working coefficients into the nonvolatile store.
// R15: Download copies nonvolatile coefficients into working memory.
// R16: A readable counter counts writes to the nonvolatile store.
// R17: No calibration runs after reset until commanded.
// R18: Completion flag set when calibration finishes.
// R19: Each sample corrected by its channel/range gain and offset.
// R20: Completion flag cleared when a new calibration starts.
module calcmd_ctrl import calcmd_pkg::*; #(
  parameter int AVG_LOG2  = 8,
  parameter int BLINK_CYC = BLINK_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output meas_type         meas,
  input  wire logic        meas_ack,
  input  wire logic [19:0] meas_data,
  input  wire sample_type  samp_in,
  input  wire logic        samp_valid,
  output logic             samp_ready,
  output sample_type       samp_out,
  output logic             samp_out_valid,
  output logic             led,
  output logic             busy
);

  localparam logic [15:0] AVG_LAST = 16'((1 << AVG_LOG2) - 1);
  localparam logic [31:0] BLINK_LAST = 32'(BLINK_CYC - 1);

  state_type s_r;
  state_type s_nxt;
  logic        cal_run;
  logic        wr_go;
  logic        wr_ok;
  logic        rd_ok;
  logic [31:0] sum;
  logic [15:0] avg;
  logic [2:0]  rng_last;
  logic [5:0]  cix;
  logic [31:0] prod;
  logic [15:0] gain;
  logic [15:0] offs;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------

  // Access mode check for privilege and address space
  function automatic logic mode_ok(input logic [3:0] m, input logic [31:0] a, input logic [2:0] p);
    logic ext;
    ext = |a[31:EXT_ADDR_LSB];
    mode_ok = (p[0] ? m[MODE_SUP] : m[MODE_NPRIV]) && (ext ? m[MODE_EXT] : m[MODE_STD]);
  endfunction

  // Byte-lane merge into a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] st);
    merge = old;
    if (st[0]) begin
      merge[7:0] = d[7:0];
    end
    if (st[1]) begin
      merge[15:8] = d[15:8];
    end
  endfunction

  // Coefficient index: gain at even, offset at odd entries
  function automatic logic [5:0] coef_ix(input logic [1:0] ch, input logic [2:0] rng, input logic off);
    coef_ix = 6'((int'(ch) * NUM_RNG + int'(rng)) * 2 + int'(off));
  endfunction

  // First range a channel calibrates for its polarity
  function automatic logic [2:0] rng_first(input logic [15:0] channel_config_reg);
    rng_first = channel_config_reg[POL_BIT] ? RNG_BIP_FIRST : RNG_UNI_FIRST;  // R10 R11
  endfunction

  // Reset image of all state
  function automatic state_type state_reset();
    state_type r;
    r = '0;
    r.mode = MODE_RESET;
    r.ph   = PH_IDLE;                                           // R17
    for (int i = 0; i < COEF_N; i++) begin
      r.work[i] = (i % 2 == 0) ? GAIN_UNITY : OFFSET_ZERO;
      r.nv[i]   = (i % 2 == 0) ? GAIN_UNITY : OFFSET_ZERO;
    end
    for (int c = 0; c < NUM_CH; c++) begin
      r.channel_config_reg[c] = CCR_RESET;
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Bus handshakes and shared terms
  // ---------------------------------------------------------------
  assign cal_run        = (s_r.ph == PH_SELFCAL) || (s_r.ph == PH_ATTEN) || (s_r.ph == PH_CHAN);
  assign s_axi_awready  = !s_r.aw_ok && !s_r.bvalid;
  assign s_axi_wready   = !s_r.w_ok && !s_r.bvalid;
  assign s_axi_arready  = !s_r.rvalid;
  assign s_axi_bvalid   = s_r.bvalid;
  assign s_axi_bresp    = s_r.bresp;
  assign s_axi_rvalid   = s_r.rvalid;
  assign s_axi_rdata    = s_r.rdata;
  assign s_axi_rresp    = s_r.rresp;
  assign wr_go          = s_r.aw_ok && s_r.w_ok && !s_r.bvalid;
  assign wr_ok          = mode_ok(s_r.mode, s_r.aw_addr, s_r.aw_prot);         // R2
  assign rd_ok          = mode_ok(s_r.mode, s_axi_araddr, s_axi_arprot);       // R2
  assign meas           = s_r.ph == PH_IDLE ? '0 : meas_type'{
                            req:     cal_run,
                            kind:    s_r.ph == PH_SELFCAL ? KIND_SELFCAL :
                                     (s_r.ph == PH_ATTEN ? KIND_REF : KIND_CHAN),
                            ref_sel: s_r.ref_i,
                            ch:      s_r.ch,
                            rng:     s_r.rng,
                            code:    s_r.pt ? DAC_HI : DAC_LO};
  assign samp_ready     = s_r.ph == PH_IDLE;                                   // R8
  assign samp_out       = s_r.out;
  assign samp_out_valid = s_r.out_valid;
  assign led            = s_r.led;
  assign busy           = s_r.ph != PH_IDLE;

  // Averaging and correction arithmetic
  assign sum      = s_r.acc + {12'h000, meas_data};
  assign avg      = 16'((sum >> AVG_LOG2) >> 4);                               // R9
  assign rng_last = s_r.channel_config_reg[s_r.ch][POL_BIT] ? RNG_BIP_LAST : RNG_UNI_LAST;   // R10 R11
  assign cix      = coef_ix(samp_in.ch, samp_in.rng, 1'b0);
  assign gain     = s_r.work[cix];
  assign offs     = s_r.work[cix + 6'h01];
  assign prod     = samp_in.data * gain;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;

    // Address and data capture in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.aw_ok   = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
      s_nxt.aw_prot = s_axi_awprot;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.w_ok  = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end

    // Write execution; discarded whole while calibrating
    if (wr_go) begin
      s_nxt.aw_ok  = 1'b0;
      s_nxt.w_ok   = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = RESP_OKAY;
      if (cal_run) begin
        s_nxt.bresp = RESP_OKAY;  // R6
      end else if (!wr_ok) begin
        s_nxt.bresp = RESP_SLVERR;
      end else if (s_r.aw_addr[7:4] == ADDR_CCR_PAGE && s_r.aw_addr[1:0] == 2'h0) begin
        s_nxt.channel_config_reg[s_r.aw_addr[3:2]] = merge(s_r.channel_config_reg[s_r.aw_addr[3:2]], s_r.wdata, s_r.wstrb); // R1
      end else begin
        case (s_r.aw_addr[7:0])
          ADDR_CMD: begin
            // Command only from a lone byte write, and only when idle
            if (s_r.wstrb == STRB_BYTE0 && s_r.ph == PH_IDLE) begin           // R3 R8
              case (s_r.wdata[7:0])
                CMD_START_CAL: begin
                  s_nxt.ph       = PH_SELFCAL;  // R4
                  s_nxt.cal_done = 1'b0;  // R20
                  s_nxt.blink    = '0;
                end
                CMD_UPLOAD: begin
                  s_nxt.ph      = PH_COPY;
                  s_nxt.copy_up = 1'b1;
                  s_nxt.idx     = '0;
                end
                CMD_DOWNLOAD: begin
                  s_nxt.ph      = PH_COPY;
                  s_nxt.copy_up = 1'b0;
                  s_nxt.idx     = '0;
                end
                default: begin
                  s_nxt.ph = s_r.ph;
                end
              endcase
            end
          end
          ADDR_MODE:     s_nxt.mode     = 4'(merge({12'h000, s_r.mode}, s_r.wdata, s_r.wstrb)); // R1
          ADDR_COEF_SEL: s_nxt.coef_sel = 6'(merge({10'h000, s_r.coef_sel}, s_r.wdata, s_r.wstrb));
          ADDR_STATUS, ADDR_NV_COUNT, ADDR_COEF_DATA: s_nxt.bresp = RESP_OKAY;
          default:       s_nxt.bresp = RESP_SLVERR;
        endcase
      end
    end

    // Read: answer one cycle after the address is taken
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = RESP_OKAY;
      s_nxt.rdata  = '0;
      if (cal_run) begin
        s_nxt.rdata = {16'h0000, BUSY_READ_VAL};  // R5
      end else if (!rd_ok) begin
        s_nxt.rresp = RESP_SLVERR;
      end else if (s_axi_araddr[7:4] == ADDR_CCR_PAGE && s_axi_araddr[1:0] == 2'h0) begin
        s_nxt.rdata[15:0] = s_r.channel_config_reg[s_axi_araddr[3:2]];
      end else begin
        case (s_axi_araddr[7:0])
          ADDR_CMD:       s_nxt.rdata = '0;
          ADDR_STATUS: begin
            s_nxt.rdata[ST_BUSY] = s_r.ph != PH_IDLE;
            s_nxt.rdata[ST_CAL]  = cal_run;
            s_nxt.rdata[ST_DONE] = s_r.cal_done;                               // R18
            s_nxt.rdata[ST_LED]  = s_r.led;
          end
          ADDR_NV_COUNT:  s_nxt.rdata[15:0] = s_r.nv_count;                   // R16
          ADDR_MODE:      s_nxt.rdata[3:0]  = s_r.mode;
          ADDR_COEF_SEL:  s_nxt.rdata[5:0]  = s_r.coef_sel;
          ADDR_COEF_DATA: s_nxt.rdata[15:0] = s_r.coef_sel < 6'(COEF_N) ? s_r.work[s_r.coef_sel] : 16'h0000;
          default:        s_nxt.rresp = RESP_SLVERR;
        endcase
      end
    end

    // Calibration sequencer and coefficient copies
    case (s_r.ph)
      PH_IDLE: begin
        s_nxt.acc = '0;
        s_nxt.cnt = '0;
      end
      PH_SELFCAL: begin
        if (meas_ack) begin
          s_nxt.ph    = PH_ATTEN;  // R7
          s_nxt.ref_i = '0;
          s_nxt.acc   = '0;
          s_nxt.cnt   = '0;
        end
      end
      PH_ATTEN: begin
        if (meas_ack) begin
          s_nxt.acc = sum;                                                     // R9
          s_nxt.cnt = s_r.cnt + 16'h0001;
          if (s_r.cnt == AVG_LAST) begin
            s_nxt.atten[s_r.ref_i] = avg;
            s_nxt.acc = '0;
            s_nxt.cnt = '0;
            if (s_r.ref_i == REF_LAST) begin
              s_nxt.ph  = PH_CHAN;  // R7
              s_nxt.ch  = '0;
              s_nxt.rng = rng_first(s_r.channel_config_reg[0]);
              s_nxt.pt  = 1'b0;
            end else begin
              s_nxt.ref_i = s_r.ref_i + 2'h1;
            end
          end
        end
      end
      PH_CHAN: begin
        if (meas_ack) begin
          s_nxt.acc = sum;                                                     // R9
          s_nxt.cnt = s_r.cnt + 16'h0001;
          if (s_r.cnt == AVG_LAST) begin
            s_nxt.acc = '0;
            s_nxt.cnt = '0;
            if (!s_r.pt) begin
              s_nxt.lo = avg;
              s_nxt.pt = 1'b1;
            end else begin
              // Two-point fit written to working memory only
              s_nxt.work[coef_ix(s_r.ch, s_r.rng, 1'b0)] = avg - s_r.lo;      // R13
              s_nxt.work[coef_ix(s_r.ch, s_r.rng, 1'b1)] = s_r.lo;
              s_nxt.pt = 1'b0;
              if (s_r.rng != rng_last) begin
                s_nxt.rng = s_r.rng + 3'h1;  // R10
              end else if (s_r.ch != CH_LAST) begin
                s_nxt.ch  = s_r.ch + 2'h1;
                s_nxt.rng = rng_first(s_r.channel_config_reg[s_r.ch + 2'h1]);
              end else begin
                s_nxt.ph       = PH_IDLE;
                s_nxt.cal_done = 1'b1;  // R18
              end
            end
          end
        end
      end
      PH_COPY: begin
        if (s_r.copy_up) begin
          s_nxt.nv[s_r.idx] = s_r.work[s_r.idx];  // R14
        end else begin
          s_nxt.work[s_r.idx] = s_r.nv[s_r.idx];  // R15
        end
        s_nxt.idx = s_r.idx + 6'h01;
        if (s_r.idx == 6'(COEF_N - 1)) begin
          s_nxt.ph = PH_IDLE;
          if (s_r.copy_up && s_r.nv_count != NV_COUNT_MAX) begin
            s_nxt.nv_count = s_r.nv_count + 16'h0001;                          // R16
          end
        end
      end
      default: begin
        s_nxt.ph = PH_IDLE;
      end
    endcase

    // Front panel indicator blinks while calibrating
    if (cal_run) begin
      s_nxt.blink = s_r.blink + 32'h0000_0001;
      if (s_r.blink >= BLINK_LAST) begin
        s_nxt.blink = '0;
        s_nxt.led   = !s_r.led;  // R4
      end
    end else begin
      s_nxt.blink = '0;
      s_nxt.led   = 1'b0;
    end

    // Per-sample gain and offset correction
    s_nxt.out_valid = samp_valid && samp_ready;
    if (samp_valid && samp_ready) begin
      s_nxt.out.ch   = samp_in.ch;
      s_nxt.out.rng  = samp_in.rng;
      s_nxt.out.data = prod[31:16] + offs;  // R19
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= state_reset();
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

`default_nettype wire

// >>> rtl/calcmd_pkg.sv
// Shared constants and types for the calibration command controller
package calcmd_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CMD       = 8'h00;
  localparam logic [7:0] ADDR_STATUS    = 8'h04;
  localparam logic [7:0] ADDR_NV_COUNT  = 8'h08;
  localparam logic [7:0] ADDR_MODE      = 8'h0c;
  localparam logic [7:0] ADDR_COEF_SEL  = 8'h10;
  localparam logic [7:0] ADDR_COEF_DATA = 8'h14;
  localparam logic [3:0] ADDR_CCR_PAGE  = 4'h2;   // 0x20..0x2c, one per channel

  // ---------------------------------------------------------------
  // Command codes, written as one byte to ADDR_CMD
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_START_CAL = 8'h01;
  localparam logic [7:0] CMD_UPLOAD    = 8'h02;
  localparam logic [7:0] CMD_DOWNLOAD  = 8'h03;
  localparam logic [3:0] STRB_BYTE0    = 4'h1;

  // ---------------------------------------------------------------
  // Fields and values
  // ---------------------------------------------------------------
  localparam int          POL_BIT       = 12;       // 1 = bipolar channel
  localparam int          ST_BUSY       = 0;
  localparam int          ST_CAL        = 1;
  localparam int          ST_DONE       = 2;
  localparam int          ST_LED        = 3;
  localparam int          MODE_SUP      = 0;
  localparam int          MODE_NPRIV    = 1;
  localparam int          MODE_STD      = 2;
  localparam int          MODE_EXT      = 3;
  localparam logic [3:0]  MODE_RESET    = 4'hf;
  localparam int          EXT_ADDR_LSB  = 24;       // any bit set here or above: extended
  localparam logic [15:0] BUSY_READ_VAL = 16'h3c00;
  localparam logic [15:0] GAIN_UNITY    = 16'hffff;
  localparam logic [15:0] OFFSET_ZERO   = 16'h0000;
  localparam logic [15:0] CCR_RESET     = 16'h0000;
  localparam logic [15:0] NV_COUNT_MAX  = 16'hffff;
  localparam logic [15:0] DAC_LO        = 16'h0000;
  localparam logic [15:0] DAC_HI        = 16'hffff;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // Ranges: 0..+10, 0..+5 unipolar; +-2.5, +-5, +-10 bipolar
  localparam int          NUM_CH        = 4;
  localparam int          NUM_RNG       = 5;
  localparam int          COEF_N        = NUM_CH * NUM_RNG * 2;
  localparam logic [2:0]  RNG_UNI_FIRST = 3'h0;
  localparam logic [2:0]  RNG_UNI_LAST  = 3'h1;
  localparam logic [2:0]  RNG_BIP_FIRST = 3'h2;
  localparam logic [2:0]  RNG_BIP_LAST  = 3'h4;
  localparam logic [1:0]  REF_LAST      = 2'h2;     // 2.5 V, 5 V, 10 V
  localparam logic [1:0]  CH_LAST       = 2'h3;

  // Measurement request kinds
  localparam logic [1:0]  KIND_SELFCAL  = 2'h0;
  localparam logic [1:0]  KIND_REF      = 2'h1;
  localparam logic [1:0]  KIND_CHAN     = 2'h2;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int BLINK_HALF_MS = 250;
  localparam int BLINK_CYCLES  = (BLINK_HALF_MS * 1000000) / (CLK_PERIOD_PS / 1000);

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {PH_IDLE, PH_SELFCAL, PH_ATTEN, PH_CHAN, PH_COPY} phase_type;

  typedef struct packed {
    logic        req;
    logic [1:0]  kind;
    logic [1:0]  ref_sel;
    logic [1:0]  ch;
    logic [2:0]  rng;
    logic [15:0] code;
  } meas_type;

  typedef struct packed {
    logic [1:0]  ch;
    logic [2:0]  rng;
    logic [15:0] data;
  } sample_type;

  typedef struct packed {
    logic                     aw_ok;
    logic [31:0]              aw_addr;
    logic [2:0]               aw_prot;
    logic                     w_ok;
    logic [31:0]              wdata;
    logic [3:0]               wstrb;
    logic                     bvalid;
    logic [1:0]               bresp;
    logic                     rvalid;
    logic [31:0]              rdata;
    logic [1:0]               rresp;
    logic [3:0][15:0]         channel_config_reg;
    logic [3:0]               mode;
    logic [5:0]               coef_sel;
    logic                     cal_done;
    phase_type                ph;
    logic [1:0]               ref_i;
    logic [1:0]               ch;
    logic [2:0]               rng;
    logic                     pt;
    logic [15:0]              cnt;
    logic [31:0]              acc;
    logic [15:0]              lo;
    logic [2:0][15:0]         atten;
    logic                     copy_up;
    logic [5:0]               idx;
    logic [COEF_N-1:0][15:0]  work;
    logic [COEF_N-1:0][15:0]  nv;
    logic [15:0]              nv_count;
    logic [31:0]              blink;
    logic                     led;
    logic                     out_valid;
    sample_type               out;
  } state_type;

endpackage

// >>> bench/calcmd_meas_model.sv
// Converter stand-in that answers calibration measurement requests
`timescale 1ns/1ps
`default_nettype none
module meas_model import calcmd_pkg::*; (
  input  wire logic     aclk,
  input  wire logic     aresetn,
  input  wire meas_type meas,
  input  wire logic     slow,
  output logic          meas_ack,
  output logic [19:0]   meas_data
);
  logic [1:0]  gap_r;
  logic [19:0] val;
  // Distinct low and high channel readings
  assign val = (meas.kind == KIND_CHAN) ? ((meas.code == DAC_HI) ? 20'hf1000 : 20'h01000) : 20'h00000;
  // Data is not held outside the acknowledge
  assign meas_data = meas_ack ? val : ~val;
  // One reading per pulse, every second or fourth cycle
  always_ff @(posedge aclk) begin
    gap_r    <= aresetn ? gap_r + 2'h1 : 2'h0;
    meas_ack <= aresetn && meas.req && (slow ? gap_r == 2'h3 : gap_r[0]);
  end
endmodule
`default_nettype wire

// >>> bench/calcmd_ctrl_monitor.sv
// Assertion checker for the calibration command controller
`timescale 1ns/1ps
`default_nettype none
module calcmd_ctrl_monitor import calcmd_pkg::*; (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire meas_type    meas,
  input wire logic        meas_ack,
  input wire logic        samp_valid,
  input wire logic        samp_ready,
  input wire logic        samp_out_valid,
  input wire logic        led,
  input wire logic        busy
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic w_hs;
  logic s_hs;
  logic start_hs;
  // Handshakes and an idle start command offered in one beat
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign s_hs = samp_valid && samp_ready;
  assign start_hs = w_hs && s_axi_awvalid && !busy && s_axi_awaddr == {24'h0, ADDR_CMD}
                    && s_axi_wstrb == STRB_BYTE0 && s_axi_wdata[7:0] == CMD_START_CAL;
  cmd_start_a: assert property (start_hs |-> ##[1:3] (meas.req && meas.kind == KIND_SELFCAL))
    else $error("start ignored");
  no_spont_a: assert property ($rose(meas.req) |-> $past(w_hs, 2) || $past(w_hs, 3))
    else $error("uncommanded calibration");
  selfcal_ref_a: assert property (meas.req && meas.kind == KIND_SELFCAL && meas_ack |=> meas.kind == KIND_REF && meas.ref_sel == 2'h0)
    else $error("no reference pass");
  chan_after_ref_a: assert property ($rose(meas.req && meas.kind == KIND_CHAN) |-> $past(meas.kind) == KIND_REF && $past(meas.ref_sel) == REF_LAST)
    else $error("early channel pass");
  busy_read_a: assert property (s_axi_arvalid && s_axi_arready && meas.req |=> s_axi_rvalid && s_axi_rdata == 32'h00003c00)
    else $error("busy read value");
  samp_hold_a: assert property (busy |=> !samp_out_valid)
    else $error("output while busy");
  samp_out_a: assert property (samp_out_valid == $past(s_hs))
    else $error("sample pulse");
  led_blink_a: assert property ((meas.req && $stable(led)) [*6] |-> 1'b0)
    else $error("no blinking");
  // Main scenarios reached
  cover property (start_hs);
  cover property (meas_ack && meas.kind == KIND_CHAN);
  cover property (samp_out_valid);
endmodule
bind calcmd_ctrl calcmd_ctrl_monitor calcmd_ctrl_monitor_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .meas, .meas_ack, .samp_valid, .samp_ready, .samp_out_valid, .led, .busy);
`default_nettype wire

// >>> bench/calibration_command_control_tb_top.sv
// Self-checking bench for the calibration command controller
`timescale 1ns/1ps
`default_nettype none
module calibration_command_control_tb_top import calcmd_pkg::*; ;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        slow = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = '0;
  logic [2:0]  s_axi_awprot = '0, s_axi_arprot = '0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, samp_valid = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        meas_ack, samp_ready, samp_out_valid, led, busy;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [19:0] meas_data;
  meas_type    meas;
  sample_type  samp_in = '0, samp_out;
  int          fail_count = 0, tests_run = 0;
  // Clock and design with short averaging and blink counts
  always #2.5 aclk = ~aclk;
  calcmd_ctrl #(.AVG_LOG2(1), .BLINK_CYC(4)) calcmd_ctrl_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .meas, .meas_ack, .meas_data, .samp_in, .samp_valid,
    .samp_ready, .samp_out, .samp_out_valid, .led, .busy);
  meas_model meas_model_i (.aclk, .aresetn, .meas, .slow, .meas_ack, .meas_data);
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] st);
    @(posedge aclk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_awprot <= 3'h1;
    s_axi_wdata <= {16'h0, d};
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check("bresp", 32'(s_axi_bresp), 32'(RESP_OKAY));
  endtask
  task automatic rd(input logic [31:0] a, input logic [15:0] ed, input logic [1:0] er = RESP_OKAY,
                    input logic [2:0] p = 3'h1);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arprot <= p;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    check("rresp", 32'(s_axi_rresp), 32'(er));
    if (er === RESP_OKAY) check("rdata", s_axi_rdata, {16'h0, ed});
  endtask
  task automatic cmd(input logic [7:0] c);
    wr(ADDR_CMD, {8'h0, c}, STRB_BYTE0);
  endtask
  task automatic coef(input logic [5:0] i, input logic [15:0] e);
    wr(ADDR_COEF_SEL, {10'h0, i}, 4'h3);
    rd(ADDR_COEF_DATA, e);
  endtask
  task automatic samp(input logic [1:0] c, input logic [15:0] d, input logic [15:0] e);
    @(posedge aclk);
    samp_in <= '{c, 3'h0, d};
    samp_valid <= 1'b1;
    @(posedge aclk);
    samp_valid <= 1'b0;
    #1;
    check("samp_out_valid", 32'(samp_out_valid), 32'h1);
    check("samp_out", 32'(samp_out.data), 32'(e));
  endtask
  task automatic wait_idle();
    repeat (2000) if (busy === 1'b1) @(posedge aclk);
    check("busy", 32'(busy), 32'h0);
  endtask
  task automatic complete_run();
    if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard
  initial begin
    #200000;
    fail_count++;
    complete_run();
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_STATUS, 16'h0);
    rd(ADDR_MODE, 16'h000f);
    rd(ADDR_NV_COUNT, 16'h0);
    rd(32'h18, 16'h0, RESP_SLVERR);
    for (int i = 0; i < 4; i++) wr(8'h20 + 8'(4 * i), (i == 1) ? 16'h1000 : 16'h2a77, (i == 0) ? 4'h2 : 4'h3);
    rd(8'h20, 16'h2a00);
    rd(8'h24, 16'h1000);
    wr(ADDR_MODE, 16'h0005, 4'h1);
    rd(ADDR_MODE, 16'h0005);
    rd(ADDR_MODE, 16'h0, RESP_SLVERR, 3'h0);
    rd(32'h0100000c, 16'h0, RESP_SLVERR);
    wr(ADDR_MODE, 16'h000f, 4'h1);
    wr(ADDR_CMD, 16'h0001, 4'h3);
    repeat (4) @(posedge aclk);
    check("busy", 32'(busy), 32'h0);
    cmd(CMD_START_CAL);
    check("samp_ready", 32'(samp_ready), 32'h0);
    rd(ADDR_MODE, 16'h3c00);
    wr(ADDR_MODE, 16'h0000, 4'h1);
    cmd(CMD_UPLOAD);
    wait_idle();
    rd(ADDR_STATUS, 16'h0004);
    rd(ADDR_MODE, 16'h000f);
    rd(ADDR_NV_COUNT, 16'h0);
    coef(6'h00, 16'hf000);
    coef(6'h01, 16'h0100);
    coef(6'h0a, 16'hffff);
    coef(6'h0e, 16'hf000);
    coef(6'h22, 16'hffff);
    samp(2'h0, 16'h8000, 16'h7900);
    samp(2'h1, 16'h8000, 16'h7fff);
    cmd(CMD_DOWNLOAD);
    wait_idle();
    coef(6'h00, 16'hffff);
    slow <= 1'b1;
    cmd(CMD_START_CAL);
    wait_idle();
    cmd(CMD_UPLOAD);
    wait_idle();
    rd(ADDR_NV_COUNT, 16'h0001);
    cmd(CMD_DOWNLOAD);
    wait_idle();
    coef(6'h00, 16'hf000);
    complete_run();
  end
endmodule
`default_nettype wire
